/* File: src/mcid_params.svh */
// offsets, field positions, constant values and timing for the id bank
`ifndef MCID_PARAMS_SVH
`define MCID_PARAMS_SVH

`define MCID_OFS_PORTS      12'hfd0
`define MCID_OFS_RSVD5      12'hfd4
`define MCID_OFS_RSVD6      12'hfd8
`define MCID_OFS_RSVD7      12'hfdc
`define MCID_OFS_ID0        12'hfe0
`define MCID_OFS_ID1        12'hfe4
`define MCID_OFS_ID2        12'hfe8
`define MCID_OFS_ID3        12'hfec
`define MCID_OFS_CONFIG     12'hfc0

`define MCID_PART_CODE      12'h5a5
`define MCID_MAKER_CODE     8'h3c
`define MCID_REVISION       4'h0
`define MCID_MEM_PORTS_M1   4'h9
`define MCID_STATIC_PRESENT 1'h1
`define MCID_BUS_WIDTH      3'h1
`define MCID_SLAVE_PORTS_M1 4'h9
`define MCID_RSVD_FILL      32'h0000_0000

`define MCID_ID_CFG_MSB     31
`define MCID_ID_REV_LSB     20
`define MCID_ID_MAKER_LSB   12
`define MCID_ID_PART_LSB    0

`define MCID_ACK_CYCLES     1

`endif

/* File: src/mcid_pkg.sv */
// types for the identification register bank
package mcid_pkg;
	typedef enum logic [3:0] {
		MCID_SEL_NONE,
		MCID_SEL_ID0,
		MCID_SEL_ID1,
		MCID_SEL_ID2,
		MCID_SEL_ID3,
		MCID_SEL_PORTS,
		MCID_SEL_RSVD,
		MCID_SEL_CONFIG
	} mcid_sel_t;
endpackage : mcid_pkg

/* File: src/mcid_decode.sv */
// address decoder selecting one identification register
`timescale 1ns/1ps
`include "mcid_params.svh"
module mcid_decode
	import mcid_pkg::*;
(
	input  wire logic [11:0] adr_i,
	output mcid_sel_t        sel_o
);
	always_comb begin
		case (adr_i)
			`MCID_OFS_ID0:    sel_o = MCID_SEL_ID0;
			`MCID_OFS_ID1:    sel_o = MCID_SEL_ID1;
			`MCID_OFS_ID2:    sel_o = MCID_SEL_ID2;
			`MCID_OFS_ID3:    sel_o = MCID_SEL_ID3;
			`MCID_OFS_PORTS:  sel_o = MCID_SEL_PORTS;
			`MCID_OFS_RSVD5:  sel_o = MCID_SEL_RSVD;
			`MCID_OFS_RSVD6:  sel_o = MCID_SEL_RSVD;
			`MCID_OFS_RSVD7:  sel_o = MCID_SEL_RSVD;
			`MCID_OFS_CONFIG: sel_o = MCID_SEL_CONFIG;
			default:          sel_o = MCID_SEL_NONE;
		endcase
	end
endmodule : mcid_decode

/* File: src/mcid_word.sv */
// builds the conceptual 32-bit identifier from its fields
`timescale 1ns/1ps
`include "mcid_params.svh"
module mcid_word
	import mcid_pkg::*;
(
	input  wire logic [11:0] part_i,
	input  wire logic [7:0]  maker_i,
	input  wire logic [3:0]  rev_i,
	input  wire logic [7:0]  cfg_i,
	output logic      [31:0] id_o
);
	assign id_o = {cfg_i, rev_i, maker_i, part_i};
endmodule : mcid_word

/* File: src/mcid_regs.sv */
// wishbone slave holding the hard-coded identification registers
//
// Summary of operation
// - port-count register low nibble is ports minus one, here nine.
// - reserved upper bits read undefined; software leaves them alone.
// - the three registers after the port count are fully reserved.
// - four read-only byte identifiers on consecutive words fe0 to fec.
// - bytes join to one word, lowest address lowest byte.
// - word holds config, revision, maker code, part code, top down.
// - first byte returns low eight bits of part code.
// - second byte: maker low nibble above part high nibble.
// - third byte: revision above maker high nibble.
// - fourth byte bit 7 set: static controller present.
// - fourth byte bits 6:4 give master bus width, here 64 bits.
// - fourth byte low nibble is slave ports minus one, here nine.
// - every value is a constant, unaffected by reset or programming.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`include "mcid_params.svh"
module mcid_regs
	import mcid_pkg::*;
#(
	parameter logic [11:0] PART_CODE  = `MCID_PART_CODE,
	parameter logic [7:0]  MAKER_CODE = `MCID_MAKER_CODE,
	parameter logic [3:0]  REVISION   = `MCID_REVISION
)(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [31:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	output logic             read_seen_o
);
	// part, maker and revision defaults are arbitrary neutral values

	// ----------------------------------------
	// identifier assembly
	// ----------------------------------------
	logic [7:0]  cfg_byte;
	logic [31:0] id_word;
	logic [7:0]  ports_byte;
	assign cfg_byte = {`MCID_STATIC_PRESENT, `MCID_BUS_WIDTH,
		`MCID_SLAVE_PORTS_M1};
	assign ports_byte = {4'h0, `MCID_MEM_PORTS_M1};

	mcid_word u_word (
		.part_i  (PART_CODE),
		.maker_i (MAKER_CODE),
		.rev_i   (REVISION),
		.cfg_i   (cfg_byte),
		.id_o    (id_word)
	);

	// ----------------------------------------
	// decode
	// ----------------------------------------
	mcid_sel_t sel;
	mcid_decode u_dec (
		.adr_i (adr_i[11:0]),
		.sel_o (sel)
	);

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic        ack_ff;
	logic        nxt_ack;
	logic [31:0] dat_ff;
	logic [31:0] nxt_dat;
	logic        seen_ff;
	logic        nxt_seen;
	logic        req;
	logic [31:0] rd_val;

	// one cycle ack, drops in the cycle after
	assign req = cyc_i & stb_i & ~ack_ff;

	always_comb begin
		rd_val = 32'h0000_0000;
		case (sel)
			MCID_SEL_ID0: rd_val = {24'h0, id_word[7:0]};
			MCID_SEL_ID1: rd_val = {24'h0, id_word[15:8]};
			MCID_SEL_ID2: rd_val = {24'h0, id_word[23:16]};
			MCID_SEL_ID3: rd_val = {24'h0, id_word[31:24]};
			MCID_SEL_PORTS: rd_val = {24'h0, ports_byte};
			MCID_SEL_RSVD: rd_val = `MCID_RSVD_FILL;
			MCID_SEL_CONFIG: rd_val = id_word;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	always_comb begin
		nxt_ack  = req;
		nxt_dat  = dat_ff;
		nxt_seen = seen_ff;
		if (req && !we_i) begin
			nxt_dat  = rd_val;
			nxt_seen = 1'b1;
		end
	end

	// constants, reset only clears bus state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff  <= 1'b0;
			dat_ff  <= 32'h0000_0000;
			seen_ff <= 1'b0;
		end else begin
			ack_ff  <= nxt_ack;
			dat_ff  <= nxt_dat;
			seen_ff <= nxt_seen;
		end
	end

	assign ack_o       = ack_ff;
	// unmapped and write accesses are acked, never errored
	assign err_o       = 1'b0;
	assign dat_o       = dat_ff;
	assign read_seen_o = seen_ff;
endmodule : mcid_regs

/* File: dv/mcid_regs_checker.sv */
// assertion checker for the identification register bank
`timescale 1ns/1ps
module mcid_regs_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        err_o,
	input wire logic        read_seen_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a taken request: strobe up while no ack is pending
	wire req = cyc_i && stb_i && !ack_o;
	property rd(a, v);
		req && !we_i && adr_i[11:0] == a |=> dat_o == v;
	endproperty
	a_id_low: assert property (rd(12'hfe0, 32'ha5))
		else $error("id byte low wrong");
	a_id_second: assert property (rd(12'hfe4, 32'hc5))
		else $error("id byte second wrong");
	a_id_third: assert property (rd(12'hfe8, 32'h03))
		else $error("id byte third wrong");
	a_id_config: assert property (rd(12'hfec, 32'h99))
		else $error("id byte config wrong");
	a_port_count: assert property (rd(12'hfd0, 32'h09))
		else $error("port count wrong");
	a_rsvd_zero: assert property (rd(12'hfd4, 32'h00))
		else $error("reserved not zero");
	a_ack_next: assert property (req |=> ack_o ##1 !ack_o)
		else $error("ack timing wrong");
	a_no_err: assert property (!err_o)
		else $error("error response seen");
	a_wr_keep: assert property (req && we_i |=> $stable(dat_o))
		else $error("write changed read data");
	cover property (req && we_i);
	cover property (req && !we_i);
	cover property ($rose(read_seen_o));
endmodule : mcid_regs_checker

bind mcid_regs mcid_regs_checker u_mcid_regs_checker (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
	.read_seen_o(read_seen_o));

/* File: dv/memctrl_identification_regs_tb_top.sv */
// self-checking bench for the identification register bank
`timescale 1ns/1ps
module memctrl_identification_regs_tb_top;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [31:0] adr_i = 0, dat_i = 0, dat_o, d;
	logic [3:0]  sel_i = 4'hf;
	logic        ack_o, err_o, read_seen_o;
	int          miscompares = 0, n_tests = 0;
	// address beside expected read data; upper address bits are not decoded
	logic [63:0] rows [10] = '{64'h00000100_00000000,
		64'h20000fe0_000000a5, 64'h00000fe4_000000c5,
		64'h00000fe8_00000003, 64'h00000fc0_9903c5a5,
		64'h00000fd0_00000009, 64'h00000fd4_00000000,
		64'h00000fd8_00000000, 64'h00000fdc_00000000,
		64'h00000fec_00000099};
	always #2.5 clk_i = ~clk_i;
	mcid_regs u_mcid_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
		.read_seen_o(read_seen_o));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// the slave answers in its own time; only the watchdog cuts a hang short
	task automatic xfer(input logic w, input logic [31:0] a,
		output logic [31:0] r);
		cyc_i <= 1;
		stb_i <= 1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= ~a;
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		r = dat_o;
		cyc_i <= 0;
		stb_i <= 0;
		we_i  <= 0;
		@(posedge clk_i);
	endtask : xfer
	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk({31'h0, read_seen_o}, 32'h0);
		foreach (rows[i]) begin
			xfer(0, rows[i][63:32], d);
			chk(d, rows[i][31:0]);
		end
		chk({31'h0, read_seen_o}, 32'h1);
		xfer(1, 32'hfe0, d);
		chk(d, 32'h99);
		xfer(0, 32'hfe0, d);
		chk(d, 32'ha5);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		chk(dat_o, 32'h0);
		rst_i <= 0;
		@(posedge clk_i);
		xfer(0, 32'hfec, d);
		chk(d, 32'h99);
		final_report;
	end
	initial begin
		#5000;
		miscompares++;
		final_report;
	end
endmodule : memctrl_identification_regs_tb_top
